// [hw/lpb_pkg.sv]
// Constants and types shared by the local bus controller files
package lpb_pkg;
    localparam int LPB_NCS           = 8;
    localparam int LPB_AW            = 26;
    localparam int LPB_DW            = 32;
    localparam int LPB_WSW           = 16;
    localparam int LPB_CNTW          = LPB_WSW + 1;
    localparam int LPB_DCW           = 4;
    localparam int LPB_TSZW          = 2;
    localparam int LPB_FIFO_DEPTH    = 4;
    localparam int LPB_SYS_CLK_HZ    = 20_000_000;
    localparam int LPB_PCI_MAX_HZ    = 66_000_000;
    localparam int LPB_PCI_DIV_MIN   = (LPB_SYS_CLK_HZ + LPB_PCI_MAX_HZ - 1) / LPB_PCI_MAX_HZ;
    localparam int LPB_PCI_DIV       = (LPB_PCI_DIV_MIN < 2) ? 2 : LPB_PCI_DIV_MIN;
    localparam int LPB_CS_BASE_TICKS = 2;
    localparam int LPB_ACK_MIN_TICKS = 1;
    localparam logic       LPB_RW_READ         = 1'b1;
    localparam logic [1:0] LPB_BUS_LEGACY      = 2'h0;
    localparam logic [1:0] LPB_BUS_BURST       = 2'h1;
    localparam logic [1:0] LPB_BUS_MUXED       = 2'h2;
    localparam logic [1:0] LPB_SUB_NORMAL      = 2'h0;
    localparam logic [1:0] LPB_SUB_LARGE_FLASH = 2'h1;
    localparam logic [1:0] LPB_SUB_GRAPHICS    = 2'h2;

    typedef enum logic [2:0] {
        LPB_IDLE,
        LPB_SETUP,
        LPB_ACTIVE,
        LPB_HOLD,
        LPB_DEAD
    } lpb_state_type;
endpackage

// [hw/lpb_fifo.sv]
// Request FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module lpb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic             space;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [CW-1:0]    next_count;
    logic             next_space;
    logic             push;
    logic             pop;

    function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
        wrap_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    assign in_ready  = space;
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && space;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_wr_ptr = push ? wrap_inc(wr_ptr) : wr_ptr;
        next_rd_ptr = pop ? wrap_inc(rd_ptr) : rd_ptr;
        next_count  = count + CW'(push) - CW'(pop);
        next_space  = (next_count != CW'(DEPTH));
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
            space  <= 1'b0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
            space  <= next_space;
        end
    end

    // Storage needs no reset
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule
`default_nettype wire

// [hw/lpb_ctrl.sv]
// Local bus controller, non-multiplexed chip-select access
`timescale 1ns/1ps
`default_nettype none
module lpb_ctrl
    import lpb_pkg::*;
#(
    parameter int PCI_DIV = lpb_pkg::LPB_PCI_DIV,
    parameter int NCS     = lpb_pkg::LPB_NCS,
    parameter int AW      = lpb_pkg::LPB_AW,
    parameter int DW      = lpb_pkg::LPB_DW
) (
    // Clock and reset
    input  wire logic                               sys_clk,
    input  wire logic                               rst_n,
    // Access requests
    input  wire logic                               req_valid,
    output logic                                    req_ready,
    input  wire logic                               req_read,
    input  wire logic [AW-1:0]                      req_addr,
    input  wire logic [DW-1:0]                      req_wdata,
    input  wire logic [lpb_pkg::LPB_TSZW-1:0]       req_size,
    // Access answers
    output logic                                    acc_done,
    output logic                                    acc_err,
    output logic                                    rd_valid,
    output logic      [DW-1:0]                      rd_data,
    output logic                                    busy,
    // Configuration
    input  wire logic [1:0]                         cfg_bus_mode,
    input  wire logic [NCS-1:0]                     cfg_cs_en,
    input  wire logic [NCS-1:0][AW-1:0]             cfg_cs_base,
    input  wire logic [NCS-1:0][AW-1:0]             cfg_cs_mask,
    input  wire logic [NCS-1:0][1:0]                cfg_cs_submode,
    input  wire logic [NCS-1:0][lpb_pkg::LPB_WSW-1:0] wait_state_count,
    input  wire logic [NCS-1:0][lpb_pkg::LPB_DCW-1:0] dead_cycle_count,
    // Bus pins
    output logic                                    pci_clk,
    output logic      [NCS-1:0]                     lpb_cs_n,
    output logic      [AW-1:0]                      lpb_addr,
    output logic                                    lpb_rw,
    output logic                                    lpb_oe_n,
    output logic                                    transfer_start_strobe_n,
    output logic      [lpb_pkg::LPB_TSZW-1:0]       transfer_size_code,
    output logic      [DW-1:0]                      lpb_dout,
    output logic                                    lpb_dout_en_n,
    input  wire logic [DW-1:0]                      lpb_din,
    input  wire logic                               lpb_ack_n
);
    import lpb_pkg::*;

    localparam int SELW = (NCS > 1) ? $clog2(NCS) : 1;
    localparam int DIVW = $clog2(PCI_DIV);
    localparam int FW   = 1 + LPB_TSZW + AW + DW;

    // Pin synchronisers
    logic [DW-1:0] din_s1;
    logic [DW-1:0] din_s2;
    logic          ack_s1;
    logic          ack_s2;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            din_s1 <= '0;
            din_s2 <= '0;
            ack_s1 <= 1'b1;
            ack_s2 <= 1'b1;
        end else begin
            din_s1 <= lpb_din;
            din_s2 <= din_s1;
            ack_s1 <= lpb_ack_n;
            ack_s2 <= ack_s1;
        end
    end

    // Bus clock divider; tick marks the edge where the bus clock rises
    logic [DIVW-1:0] div_cnt;
    logic [DIVW-1:0] next_div_cnt;
    logic            next_pci_clk;
    logic            tick;

    assign tick = (div_cnt == DIVW'(PCI_DIV - 1));

    always_comb begin
        next_div_cnt = tick ? '0 : div_cnt + DIVW'(1);
        next_pci_clk = (next_div_cnt < DIVW'(PCI_DIV / 2));
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= '0;
            pci_clk <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            pci_clk <= next_pci_clk;
        end
    end

    // Request FIFO
    logic          f_valid;
    logic          f_ready;
    logic [FW-1:0] f_data;
    logic          f_read;
    logic [LPB_TSZW-1:0] f_size;
    logic [AW-1:0] f_addr;
    logic [DW-1:0] f_wdata;

    lpb_fifo #(
        .WIDTH (FW),
        .DEPTH (LPB_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (req_valid),
        .in_ready  (req_ready),
        .in_data   ({req_read, req_size, req_addr, req_wdata}),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    assign {f_read, f_size, f_addr, f_wdata} = f_data;

    // Access sequencer state
    lpb_state_type       state;
    logic [LPB_CNTW-1:0] cnt;
    logic [LPB_CNTW-1:0] limit;
    logic [LPB_DCW-1:0]  dcyc;
    logic [SELW-1:0]     sel;
    logic [1:0]          sub;
    logic                read;

    lpb_state_type       next_state;
    logic [LPB_CNTW-1:0] next_cnt;
    logic [LPB_CNTW-1:0] next_limit;
    logic [LPB_DCW-1:0]  next_dcyc;
    logic [SELW-1:0]     next_sel;
    logic [1:0]          next_sub;
    logic                next_read;
    logic [NCS-1:0]      next_cs_n;
    logic [AW-1:0]       next_addr;
    logic                next_rw;
    logic                next_oe_n;
    logic                next_ts_n;
    logic [LPB_TSZW-1:0] next_transfer_size_code;
    logic [DW-1:0]       next_dout;
    logic                next_dout_en_n;
    logic [DW-1:0]       next_rd_data;
    logic                next_rd_valid;
    logic                next_done;
    logic                next_err;
    logic                next_busy;
    logic                hit;
    logic [SELW-1:0]     hit_idx;
    logic                cnt_end;
    logic                ack_end;

    function automatic logic [LPB_CNTW-1:0] cnt_inc(input logic [LPB_CNTW-1:0] c);
        cnt_inc = c + LPB_CNTW'(1);
    endfunction

    function automatic logic wide_mode(input logic [1:0] m);
        wide_mode = (m == LPB_SUB_LARGE_FLASH) || (m == LPB_SUB_GRAPHICS);
    endfunction

    // Pop only on a bus clock edge so setup lasts one full bus cycle
    assign f_ready = (state == LPB_IDLE) && tick;
    assign cnt_end = (cnt_inc(cnt) == limit);
    assign ack_end = !ack_s2 && (cnt >= LPB_CNTW'(LPB_ACK_MIN_TICKS));

    always_comb begin
        hit     = 1'b0;
        hit_idx = '0;
        for (int i = 0; i < NCS; i++) begin
            if (!hit && cfg_cs_en[i] &&
                ((f_addr & cfg_cs_mask[i]) == (cfg_cs_base[i] & cfg_cs_mask[i]))) begin
                hit     = 1'b1;
                hit_idx = SELW'(i);
            end
        end
    end

    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_limit     = limit;
        next_dcyc      = dcyc;
        next_sel       = sel;
        next_sub       = sub;
        next_read      = read;
        next_cs_n      = lpb_cs_n;
        next_addr      = lpb_addr;
        next_rw        = lpb_rw;
        next_oe_n      = lpb_oe_n;
        next_ts_n      = transfer_start_strobe_n;
        next_transfer_size_code      = transfer_size_code;
        next_dout      = lpb_dout;
        next_dout_en_n = lpb_dout_en_n;
        next_rd_data   = rd_data;
        next_rd_valid  = 1'b0;
        next_done      = 1'b0;
        next_err       = 1'b0;
        unique case (state)
            LPB_IDLE: begin
                if (f_valid && tick) begin
                    if (!hit || cfg_bus_mode != LPB_BUS_LEGACY) begin
                        next_err = 1'b1;
                    end else begin
                        next_state     = LPB_SETUP;
                        next_sel       = hit_idx;
                        next_sub       = cfg_cs_submode[hit_idx];
                        next_read      = f_read;
                        next_limit     = LPB_CNTW'(wait_state_count[hit_idx]) +
                                         LPB_CNTW'(LPB_CS_BASE_TICKS);
                        next_dcyc      = dead_cycle_count[hit_idx];
                        next_addr      = f_addr;
                        next_rw        = f_read;
                        next_dout      = f_wdata;
                        next_dout_en_n = f_read;
                        next_ts_n      = !wide_mode(cfg_cs_submode[hit_idx]);
                        next_transfer_size_code      = (cfg_cs_submode[hit_idx] == LPB_SUB_GRAPHICS) ? f_size : '0;
                    end
                end
            end
            LPB_SETUP: begin
                if (tick) begin
                    next_state      = LPB_ACTIVE;
                    next_cnt        = '0;
                    next_cs_n       = '1;
                    next_cs_n[sel]  = 1'b0;
                    next_oe_n       = !read;
                    next_ts_n       = 1'b1;
                end
            end
            LPB_ACTIVE: begin
                if (tick) begin
                    next_cnt = cnt_inc(cnt);
                    if (cnt_end || ack_end) begin
                        next_state = LPB_HOLD;
                        next_cs_n  = '1;
                        next_oe_n  = 1'b1;
                        if (read) begin
                            next_rd_data  = din_s2;
                            next_rd_valid = 1'b1;
                        end
                        if (wide_mode(sub)) begin
                            next_addr = '0;
                        end
                    end
                end
            end
            LPB_HOLD: begin
                // One internal clock of hold after select release
                next_addr      = '0;
                next_rw        = LPB_RW_READ;
                next_dout_en_n = 1'b1;
                next_transfer_size_code      = '0;
                next_done      = 1'b1;
                next_cnt       = '0;
                next_limit     = LPB_CNTW'(dcyc) + LPB_CNTW'(1);
                next_state     = read ? LPB_DEAD : LPB_IDLE;
            end
            LPB_DEAD: begin
                // Far side may still drive data; bus stays undriven
                if (tick) begin
                    next_cnt = cnt_inc(cnt);
                    if (cnt_end) begin
                        next_state = LPB_IDLE;
                    end
                end
            end
        endcase
        next_busy = (next_state != LPB_IDLE);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state                   <= LPB_IDLE;
            cnt                     <= '0;
            limit                   <= '0;
            dcyc                    <= '0;
            sel                     <= '0;
            sub                     <= LPB_SUB_NORMAL;
            read                    <= 1'b0;
            lpb_cs_n                <= '1;
            lpb_addr                <= '0;
            lpb_rw                  <= LPB_RW_READ;
            lpb_oe_n                <= 1'b1;
            transfer_start_strobe_n <= 1'b1;
            transfer_size_code      <= '0;
            lpb_dout                <= '0;
            lpb_dout_en_n           <= 1'b1;
            rd_data                 <= '0;
            rd_valid                <= 1'b0;
            acc_done                <= 1'b0;
            acc_err                 <= 1'b0;
            busy                    <= 1'b0;
        end else begin
            state                   <= next_state;
            cnt                     <= next_cnt;
            limit                   <= next_limit;
            dcyc                    <= next_dcyc;
            sel                     <= next_sel;
            sub                     <= next_sub;
            read                    <= next_read;
            lpb_cs_n                <= next_cs_n;
            lpb_addr                <= next_addr;
            lpb_rw                  <= next_rw;
            lpb_oe_n                <= next_oe_n;
            transfer_start_strobe_n <= next_ts_n;
            transfer_size_code      <= next_transfer_size_code;
            lpb_dout                <= next_dout;
            lpb_dout_en_n           <= next_dout_en_n;
            rd_data                 <= next_rd_data;
            rd_valid                <= next_rd_valid;
            acc_done                <= next_done;
            acc_err                 <= next_err;
            busy                    <= next_busy;
        end
    end
endmodule
`default_nettype wire

// [tb/lpb_ctrl_asserts.sv]
// Pin timing checker for the local bus controller
`timescale 1ns/1ps
`default_nettype none
module lpb_ctrl_asserts
    import lpb_pkg::*;
#(
    parameter int PCI_DIV = 2,
    parameter int NCS     = 8
) (
    // Clock and reset
    input wire logic                                 sys_clk,
    input wire logic                                 rst_n,
    // Configuration
    input wire logic [NCS-1:0][1:0]                  cfg_cs_submode,
    input wire logic [NCS-1:0][lpb_pkg::LPB_WSW-1:0] wait_state_count,
    // Bus pins and answers
    input wire logic                                 pci_clk,
    input wire logic [NCS-1:0]                       lpb_cs_n,
    input wire logic [lpb_pkg::LPB_AW-1:0]           lpb_addr,
    input wire logic                                 lpb_rw,
    input wire logic                                 lpb_oe_n,
    input wire logic                                 transfer_start_strobe_n,
    input wire logic [lpb_pkg::LPB_TSZW-1:0]         transfer_size_code,
    input wire logic [lpb_pkg::LPB_DW-1:0]           lpb_dout,
    input wire logic                                 lpb_dout_en_n,
    input wire logic                                 lpb_ack_n,
    input wire logic                                 rd_valid
);
    logic           cs_act;
    logic [NCS-1:0] sel;
    logic [19:0]    cs_len;
    logic           ack_seen;
    logic           big;
    logic [19:0]    full_len;
    assign cs_act = ~&lpb_cs_n;
    // Mode and full width of the select just released
    always_comb begin
        big = 1'b0;
        full_len = '0;
        for (int i = 0; i < NCS; i++) begin
            if (sel[i]) begin
                big = (cfg_cs_submode[i] == LPB_SUB_LARGE_FLASH) || (cfg_cs_submode[i] == LPB_SUB_GRAPHICS);
                full_len = 20'((2 + wait_state_count[i]) * PCI_DIV);
            end
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel <= '0;
            cs_len <= '0;
            ack_seen <= 1'b0;
        end else begin
            sel <= ~lpb_cs_n;
            cs_len <= cs_act ? cs_len + 20'h1 : 20'h0;
            ack_seen <= cs_act && (ack_seen || !lpb_ack_n);
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_one_select: assert property ($onehot0(~lpb_cs_n))
        else $error("two selects low");
    chk_cs_width: assert property ($fell(cs_act) && !ack_seen |-> cs_len == full_len)
        else $error("select width wrong");
    chk_ack_short: assert property ($fell(cs_act) && ack_seen |-> cs_len >= PCI_DIV && cs_len <= full_len)
        else $error("ack width wrong");
    chk_addr_setup: assert property ($rose(cs_act) |-> $stable(lpb_addr) && lpb_rw == $past(lpb_rw, 2))
        else $error("setup lost");
    chk_addr_hold: assert property ($fell(cs_act) && !big |-> $stable(lpb_addr) && $stable(lpb_rw))
        else $error("hold lost");
    chk_addr_release: assert property ($fell(cs_act) && big |-> lpb_addr == '0)
        else $error("address not released");
    chk_wdata_hold: assert property ((cs_act || $fell(cs_act)) && !lpb_rw |-> !lpb_dout_en_n && $stable(lpb_dout))
        else $error("write data moved");
    chk_read_float: assert property (cs_act && lpb_rw |-> lpb_dout_en_n && !lpb_oe_n)
        else $error("read drive wrong");
    // Bench gives every select one dead cycle: four idle clocks
    chk_dead_float: assert property ($fell(cs_act) && lpb_rw |-> lpb_dout_en_n [*4])
        else $error("drive in dead time");
    chk_rd_capture: assert property ($fell(cs_act) && lpb_rw |-> ##[0:1] rd_valid)
        else $error("read not captured");
    chk_strobe_width: assert property ($fell(transfer_start_strobe_n) |=>
        !transfer_start_strobe_n ##1 (transfer_start_strobe_n && $rose(cs_act)))
        else $error("strobe width wrong");
    chk_size_hold: assert property ($fell(cs_act) |-> $stable(transfer_size_code))
        else $error("size code moved");
    // Two-cycle divider
    chk_pci_clk: assert property ($rose(pci_clk) |=> !pci_clk ##1 pci_clk)
        else $error("pci clock wrong");
endmodule
bind lpb_ctrl lpb_ctrl_asserts #(.PCI_DIV(PCI_DIV), .NCS(NCS)) i_lpb_ctrl_asserts (
    .sys_clk, .rst_n, .cfg_cs_submode, .wait_state_count, .pci_clk, .lpb_cs_n, .lpb_addr, .lpb_rw,
    .lpb_oe_n, .transfer_start_strobe_n, .transfer_size_code, .lpb_dout, .lpb_dout_en_n, .lpb_ack_n, .rd_valid
);
`default_nettype wire

// [tb/lpb_ext_model.sv]
// Memory device model on the far side of the local bus
`timescale 1ns/1ps
`default_nettype none
module lpb_ext_model #(
    parameter int HOLD = 4
) (
    // Clock and control
    input  wire logic        sys_clk,
    input  wire logic        ack_en,
    // Bus pins
    input  wire logic [7:0]  lpb_cs_n,
    input  wire logic [25:0] lpb_addr,
    input  wire logic        lpb_rw,
    input  wire logic [31:0] lpb_dout,
    input  wire logic        lpb_dout_en_n,
    output logic      [31:0] lpb_din,
    output logic             lpb_ack_n
);
    logic [31:0] mem [16];
    logic [3:0]  idx;
    logic        cs_act;
    logic        was_act = 1'b0;
    int          cs_cnt  = 0;
    int          hold    = 0;
    assign cs_act = (lpb_cs_n != 8'hff);
    initial begin
        lpb_din = 32'h0;
        lpb_ack_n = 1'b1;
        foreach (mem[i]) mem[i] = 32'h0;
    end
    always @(posedge sys_clk) begin
        was_act <= cs_act;
        cs_cnt <= cs_act ? cs_cnt + 1 : 0;
        if (cs_act) idx <= lpb_addr[3:0];
        // Ack not before one bus cycle, gone with the select
        lpb_ack_n <= !(ack_en && cs_act && cs_cnt >= 2);
        if (was_act && !cs_act && !lpb_rw && !lpb_dout_en_n) mem[idx] <= lpb_dout;
        if (cs_act && lpb_rw) begin
            lpb_din <= mem[lpb_addr[3:0]];
            hold <= HOLD;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end else begin
            lpb_din <= ~lpb_din;
        end
    end
endmodule
`default_nettype wire

// [tb/lpb_ctrl_bench.sv]
// Self-checking bench for the local bus controller
`timescale 1ns/1ps
`default_nettype none
module lpb_ctrl_bench;
    import lpb_pkg::*;
    logic             sys_clk = 1'b0;
    logic             rst_n = 1'b0;
    logic             req_valid, req_ready, req_read, acc_done, acc_err, rd_valid, busy, pci_clk;
    logic [25:0]      req_addr, lpb_addr;
    logic [31:0]      req_wdata, rd_data, lpb_dout, lpb_din, rd_got;
    logic [1:0]       req_size, cfg_bus_mode, transfer_size_code, transfer_size_code_seen;
    logic [7:0]       cfg_cs_en, lpb_cs_n, cs_seen;
    logic [7:0][25:0] cfg_cs_base, cfg_cs_mask;
    logic [7:0][1:0]  cfg_cs_submode;
    logic [7:0][15:0] wait_state_count;
    logic [7:0][3:0]  dead_cycle_count;
    logic             lpb_rw, lpb_oe_n, transfer_start_strobe_n, lpb_dout_en_n, lpb_ack_n, ack_en;
    logic             ts_seen, full_seen;
    int               cs_len = 0, n_ev = 0, n_err = 0, n_mismatch = 0, samples_checked = 0;
    int               ws_of [4] = '{0, 3, 0, 0};
    logic [1:0]       sub_of [4] = '{2'h0, 2'h0, 2'h2, 2'h1};
    always #25 sys_clk = ~sys_clk;
    lpb_ctrl i_lpb_ctrl (
        .sys_clk, .rst_n, .req_valid, .req_ready, .req_read, .req_addr, .req_wdata, .req_size,
        .acc_done, .acc_err, .rd_valid, .rd_data, .busy, .cfg_bus_mode, .cfg_cs_en, .cfg_cs_base,
        .cfg_cs_mask, .cfg_cs_submode, .wait_state_count, .dead_cycle_count, .pci_clk, .lpb_cs_n,
        .lpb_addr, .lpb_rw, .lpb_oe_n, .transfer_start_strobe_n, .transfer_size_code, .lpb_dout,
        .lpb_dout_en_n, .lpb_din, .lpb_ack_n
    );
    lpb_ext_model #(.HOLD(4)) i_lpb_ext_model (
        .sys_clk, .ack_en, .lpb_cs_n, .lpb_addr, .lpb_rw, .lpb_dout, .lpb_dout_en_n, .lpb_din, .lpb_ack_n
    );
    always @(posedge sys_clk) begin
        cs_seen = cs_seen | ~lpb_cs_n;
        if (lpb_cs_n != 8'hff) begin
            cs_len++;
            transfer_size_code_seen = transfer_size_code;
        end
        if (transfer_start_strobe_n === 1'b0) ts_seen = 1'b1;
        if (rd_valid === 1'b1) rd_got = rd_data;
        if (acc_done === 1'b1 || acc_err === 1'b1) n_ev++;
        if (acc_err === 1'b1) n_err++;
        if (req_ready === 1'b0) full_seen = 1'b1;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic push(input logic rd, input logic [25:0] a, input logic [31:0] d, input logic [1:0] sz);
        req_valid <= 1'b1;
        req_read <= rd;
        req_addr <= a;
        req_wdata <= d;
        req_size <= sz;
        for (int t = 0; t < 300; t++) begin
            @(posedge sys_clk);
            if (req_ready === 1'b1) break;
        end
    endtask
    // One request, then wait for its done or refusal
    task automatic acc(input logic rd, input logic [25:0] a, input logic [31:0] d, input logic [1:0] sz);
        int n;
        n = n_ev;
        cs_seen = 8'h0;
        cs_len = 0;
        ts_seen = 1'b0;
        transfer_size_code_seen = 2'h0;
        rd_got = 32'h0;
        push(rd, a, d, sz);
        req_valid <= 1'b0;
        for (int t = 0; t < 400 && n_ev == n; t++) @(negedge sys_clk);
        check(32'(n_ev - n), 32'h1);
        @(posedge sys_clk);
    endtask
    task automatic print_verdict();
        $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        int n;
        req_valid = 1'b0;
        req_read = 1'b0;
        req_addr = '0;
        req_wdata = '0;
        req_size = '0;
        ack_en = 1'b0;
        cfg_bus_mode = LPB_BUS_LEGACY;
        cfg_cs_en = 8'h0f;
        for (int i = 0; i < 8; i++) begin
            cfg_cs_base[i] = 26'(i) << 20;
            cfg_cs_mask[i] = 26'h3f00000;
            cfg_cs_submode[i] = sub_of[i % 4];
            wait_state_count[i] = 16'(ws_of[i % 4]);
            dead_cycle_count[i] = 4'h1;
        end
        repeat (19) @(posedge sys_clk);
        @(negedge sys_clk);
        check(32'(lpb_cs_n), 32'hff);
        check(32'({lpb_rw, lpb_dout_en_n, lpb_oe_n, busy}), 32'he);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        // Normal, slow, graphics and large flash selects
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, 26'(i) << 20 | 26'(i), 32'hc0de0000 | 32'(i), 2'h3);
            check(32'(cs_seen), 32'(1 << i));
            check(32'(cs_len), 32'((2 + ws_of[i]) * LPB_PCI_DIV));
            check(32'(ts_seen), 32'(sub_of[i] != LPB_SUB_NORMAL));
            check(32'(transfer_size_code_seen), (sub_of[i] == LPB_SUB_GRAPHICS) ? 32'h3 : 32'h0);
            acc(1'b1, 26'(i) << 20 | 26'(i), 32'h0, 2'h3);
            check(rd_got, 32'hc0de0000 | 32'(i));
        end
        ack_en <= 1'b1;
        acc(1'b1, 26'h0100001, 32'h0, 2'h0);
        check(32'(cs_len < (2 + ws_of[1]) * LPB_PCI_DIV), 32'h1);
        check(rd_got, 32'hc0de0001);
        ack_en <= 1'b0;
        // Disabled select, then burst and multiplexed modes
        n = n_err;
        acc(1'b0, 26'h0400000, 32'h1, 2'h0);
        for (int m = 1; m < 3; m++) begin
            cfg_bus_mode <= 2'(m);
            acc(1'b0, 26'h0000000, 32'h1, 2'h0);
            check(32'(cs_seen), 32'h0);
        end
        cfg_bus_mode <= LPB_BUS_LEGACY;
        check(32'(n_err - n), 32'h3);
        // Fill the request queue behind slow accesses
        n = n_ev;
        full_seen = 1'b0;
        for (int k = 0; k < 6; k++) push(1'b0, 26'h0100008 + 26'(k), 32'(k), 2'h0);
        req_valid <= 1'b0;
        for (int t = 0; t < 2000 && n_ev < n + 6; t++) @(negedge sys_clk);
        check(32'(full_seen), 32'h1);
        check(32'(n_ev - n), 32'h6);
        @(posedge sys_clk);
        acc(1'b1, 26'h010000d, 32'h0, 2'h0);
        check(rd_got, 32'h5);
        repeat (2 * LPB_PCI_DIV + 2) @(negedge sys_clk);
        check(32'(busy), 32'h0);
        print_verdict();
    end
    // Whole run needs well under this span
    initial begin
        #(20000 * 50);
        n_mismatch++;
        print_verdict();
    end
endmodule
`default_nettype wire
